// *** common/cls_pkg.sv ***
// Shared constants and enumerations for the configurable logic slice.
package cls_pkg;

  localparam int CLS_TABLE_DEPTH = 16;
  localparam int CLS_ADDR_W      = 4;
  localparam int CLS_ARITH_W     = 2;
  localparam int CLS_SYNC_STAGES = 2;

  localparam logic [CLS_TABLE_DEPTH-1:0] CLS_TABLE_RESET = 16'h0000;
  localparam logic [CLS_ARITH_W-1:0]     CLS_CNT_RESET   = 2'h0;
  localparam logic [CLS_ARITH_W-1:0]     CLS_CNT_ONE     = 2'h1;
  localparam logic [CLS_ARITH_W-1:0]     CLS_CNT_TOP     = 2'h3;

  typedef enum logic [1:0] {
    CLS_MODE_LOGIC,
    CLS_MODE_RIPPLE,
    CLS_MODE_RAM,
    CLS_MODE_ROM
  } cls_mode_type;

  typedef enum logic [1:0] {
    CLS_ARITH_ADD,
    CLS_ARITH_SUB,
    CLS_ARITH_UP,
    CLS_ARITH_DOWN
  } cls_arith_type;

  typedef enum logic [1:0] {
    CLS_CMP_GE,
    CLS_CMP_NE,
    CLS_CMP_LE
  } cls_cmp_type;

endpackage

// *** hw/cls_table16.sv ***
// One sixteen-entry, one-bit lookup table that doubles as a small memory.
`timescale 1ns/1ns

module cls_table16
  import cls_pkg::*;
#(
  parameter int DEPTH  = CLS_TABLE_DEPTH,
  parameter int ADDR_W = CLS_ADDR_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              load,
  input  wire logic [DEPTH-1:0]  init,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic              wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic                   rdata
);

  logic [DEPTH-1:0] bits_q;
  logic [DEPTH-1:0] bits_d;

  // Configuration load overrides a user write issued in the same cycle.
  always_comb begin
    bits_d = bits_q;
    if (load) begin
      bits_d = init;
    end else if (we) begin
      bits_d[waddr] = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_q <= CLS_TABLE_RESET;
    end else begin
      bits_q <= bits_d;
    end
  end

  // Reads are combinational, so a write shows up on the cycle after its edge.
  assign rdata = bits_q[raddr];

endmodule

// *** hw/cls_slice.sv ***
// Configurable logic slice: lookup, ripple arithmetic, distributed RAM and ROM modes.
//
// Functional notes
// RQ1: One of four modes selected per slice.
// RQ2: Each four-input table holds sixteen programmable entries.
// RQ3: Two four-input tables or one five-input table.
// RQ4: Wider functions chain outputs of neighbouring slices.
// RQ5: Ripple mode adds, subtracts, counts up, counts down.
// RQ6: Ripple mode compares operands: ge, ne, le.
// RQ7: Fast carry variant emits generate and propagate.
// RQ8: Each table acts as sixteen by one memory.
// RQ9: One slice single-port, two slices dual-port memory.
// RQ10: Companion slice gives separate read-only port.
// RQ11: ROM mode has no write, loaded at configuration.
// RQ12: RAM writes on clock edge, reads combinational.
`timescale 1ns/1ns

module cls_slice
  import cls_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  input  wire logic                       cfg_load,
  input  cls_mode_type                    cfg_mode,
  input  wire logic [CLS_TABLE_DEPTH-1:0] cfg_init0,
  input  wire logic [CLS_TABLE_DEPTH-1:0] cfg_init1,
  input  wire logic                       cfg_five_input,
  input  cls_arith_type                   cfg_arith_op,
  input  cls_cmp_type                     cfg_cmp_op,
  input  wire logic                       cfg_fast_carry,
  input  wire logic                       cfg_read_only_port,
  input  wire logic [CLS_ADDR_W-1:0]      lut_in,
  input  wire logic                       sel5,
  input  wire logic                       cat_in,
  input  wire logic                       cat_sel,
  input  wire logic [CLS_ARITH_W-1:0]     op_a,
  input  wire logic [CLS_ARITH_W-1:0]     op_b,
  input  wire logic                       carry_in,
  input  wire logic                       cnt_en,
  input  wire logic [CLS_ADDR_W-1:0]      mem_addr,
  input  wire logic [1:0]                 mem_wdata,
  input  wire logic                       mem_we,
  input  wire logic [CLS_ADDR_W-1:0]      ro_addr,
  output cls_mode_type                    mode_out,
  output logic                            out0,
  output logic                            out1,
  output logic                            wide_out,
  output logic [CLS_ARITH_W-1:0]          sum_out,
  output logic                            carry_out,
  output logic                            cmp_out,
  output logic                            cg_out,
  output logic                            cp_out,
  output logic [1:0]                      mem_rdata
);

  // Reset is asserted asynchronously and released through two flops.
  logic [CLS_SYNC_STAGES-1:0] rst_sync_q;
  logic                       rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[CLS_SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[CLS_SYNC_STAGES-1];

  // Configuration state, captured only while configuration is loading, and the ripple counter, which also steps with cnt_en when counting up or down.
  cls_mode_type               mode_q;
  cls_mode_type               mode_d;
  cls_arith_type              arith_q;
  cls_arith_type              arith_d;
  cls_cmp_type                cmp_q;
  cls_cmp_type                cmp_d;
  logic                       five_q;
  logic                       five_d;
  logic                       fast_q;
  logic                       fast_d;
  logic                       ro_q;
  logic                       ro_d;
  logic [CLS_ARITH_W-1:0]     cnt_q;
  logic [CLS_ARITH_W-1:0]     cnt_d;

  logic                       is_logic;
  logic                       is_ripple;
  logic                       is_ram;
  logic                       is_mem;

  assign is_logic  = (mode_q == CLS_MODE_LOGIC);
  assign is_ripple = (mode_q == CLS_MODE_RIPPLE);
  assign is_ram    = (mode_q == CLS_MODE_RAM);
  assign is_mem    = (mode_q == CLS_MODE_RAM) || (mode_q == CLS_MODE_ROM);

  always_comb begin
    mode_d  = mode_q;
    arith_d = arith_q;
    cmp_d   = cmp_q;
    five_d  = five_q;
    fast_d  = fast_q;
    ro_d    = ro_q;
    cnt_d   = cnt_q;
    if (cfg_load) begin
      // RQ1: mode selection at load
      mode_d  = cfg_mode;
      arith_d = cfg_arith_op;
      cmp_d   = cfg_cmp_op;
      five_d  = cfg_five_input;
      fast_d  = cfg_fast_carry;
      ro_d    = cfg_read_only_port;
      cnt_d   = CLS_CNT_RESET;
    end else if (is_ripple && cnt_en) begin
      // RQ5: two-bit counters
      case (arith_q)
        CLS_ARITH_UP:   cnt_d = cnt_q + CLS_CNT_ONE;
        CLS_ARITH_DOWN: cnt_d = cnt_q - CLS_CNT_ONE;
        default:        cnt_d = cnt_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= CLS_MODE_LOGIC;
      arith_q <= CLS_ARITH_ADD;
      cmp_q   <= CLS_CMP_GE;
      five_q  <= 1'b0;
      fast_q  <= 1'b0;
      ro_q    <= 1'b0;
      cnt_q   <= CLS_CNT_RESET;
    end else begin
      mode_q  <= mode_d;
      arith_q <= arith_d;
      cmp_q   <= cmp_d;
      five_q  <= five_d;
      fast_q  <= fast_d;
      ro_q    <= ro_d;
      cnt_q   <= cnt_d;
    end
  end

  assign mode_out = mode_q;

  // Both tables share one read address; the mode and the read-only port setting decide who drives it.
  logic [CLS_ADDR_W-1:0] tbl_raddr;
  logic                  tbl_we;
  logic                  tbl0_rd;
  logic                  tbl1_rd;

  // RQ10: companion reads on its own port
  assign tbl_raddr = is_logic ? lut_in : (ro_q ? ro_addr : mem_addr);
  // RQ11: ROM and logic modes block writes
  assign tbl_we    = is_ram && mem_we && !cfg_load;

  // RQ2: sixteen-entry programmable tables
  cls_table16 u_table0 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (cfg_load),
    .init    (cfg_init0),
    .we      (tbl_we),
    .waddr   (mem_addr),
    .wdata   (mem_wdata[0]),
    .raddr   (tbl_raddr),
    .rdata   (tbl0_rd)
  );

  cls_table16 u_table1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (cfg_load),
    .init    (cfg_init1),
    .we      (tbl_we),
    .waddr   (mem_addr),
    .wdata   (mem_wdata[1]),
    .raddr   (tbl_raddr),
    .rdata   (tbl1_rd)
  );

  // Lookup outputs.
  logic f5;

  // RQ3: five-input combining of both tables
  assign f5       = sel5 ? tbl1_rd : tbl0_rd;
  assign out0     = is_logic && (five_q ? f5 : tbl0_rd);
  assign out1     = is_logic && !five_q && tbl1_rd;
  // RQ4: concatenation with neighbouring slice
  assign wide_out = is_logic && (cat_sel ? cat_in : f5);

  // RQ8: each table is a 16x1 memory
  // RQ9: one slice gives 16x2 storage
  // RQ12: combinational read of the word
  assign mem_rdata = is_mem ? {tbl1_rd, tbl0_rd} : 2'h0;

  // Ripple arithmetic. Subtraction adds the inverted operand, so carry_in high means no borrow in.
  logic [CLS_ARITH_W-1:0] b_eff;
  logic [CLS_ARITH_W:0]   sum_full;
  logic [CLS_ARITH_W-1:0] gen_bits;
  logic [CLS_ARITH_W-1:0] prop_bits;
  logic                   grp_gen;
  logic                   grp_prop;
  logic                   is_count;
  logic                   cnt_wrap;
  logic                   cmp_res;

  assign b_eff     = (arith_q == CLS_ARITH_SUB) ? ~op_b : op_b;
  // RQ5: add and subtract
  assign sum_full  = {1'b0, op_a} + {1'b0, b_eff} + {{CLS_ARITH_W{1'b0}}, carry_in};
  assign gen_bits  = op_a & b_eff;
  assign prop_bits = op_a ^ b_eff;
  // RQ7: carry generate and propagate
  assign grp_gen   = gen_bits[1] | (prop_bits[1] & gen_bits[0]);
  assign grp_prop  = &prop_bits;
  assign is_count  = (arith_q == CLS_ARITH_UP) || (arith_q == CLS_ARITH_DOWN);
  assign cnt_wrap  = cnt_en && ((arith_q == CLS_ARITH_UP) ? (cnt_q == CLS_CNT_TOP) : (cnt_q == CLS_CNT_RESET));

  // RQ6: operand comparison
  always_comb begin
    cmp_res = 1'b0;
    case (cmp_q)
      CLS_CMP_GE: cmp_res = (op_a >= op_b);
      CLS_CMP_NE: cmp_res = (op_a != op_b);
      CLS_CMP_LE: cmp_res = (op_a <= op_b);
      default:    cmp_res = 1'b0;
    endcase
  end

  assign sum_out   = !is_ripple ? CLS_CNT_RESET : (is_count ? cnt_q : sum_full[CLS_ARITH_W-1:0]);
  // The counter carry flags the terminal count so a neighbour can extend the count.
  assign carry_out = is_ripple && (is_count ? cnt_wrap : sum_full[CLS_ARITH_W]);
  assign cmp_out   = is_ripple && cmp_res;
  // RQ7: outputs only in fast carry variant
  assign cg_out    = is_ripple && fast_q && !is_count && grp_gen;
  assign cp_out    = is_ripple && fast_q && !is_count && grp_prop;

  // Helper copies of the loaded table images, read only by the checks below.
  // They ignore RAM writes, so the lookup checks only hold in logic mode after a load.
  logic [CLS_TABLE_DEPTH-1:0] seen0_q;
  logic [CLS_TABLE_DEPTH-1:0] seen0_d;
  logic [CLS_TABLE_DEPTH-1:0] seen1_q;
  logic [CLS_TABLE_DEPTH-1:0] seen1_d;

  always_comb begin
    seen0_d = seen0_q;
    seen1_d = seen1_q;
    if (cfg_load) begin
      seen0_d = cfg_init0;
      seen1_d = cfg_init1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen0_q <= CLS_TABLE_RESET;
      seen1_q <= CLS_TABLE_RESET;
    end else begin
      seen0_q <= seen0_d;
      seen1_q <= seen1_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_mode_capture: assert property (cfg_load |=> mode_out == $past(cfg_mode)) // RQ1
    else $error("mode not taken at configuration load");
  a_lut_lookup: assert property ((is_logic && !five_q) |-> (out0 == seen0_q[lut_in] && out1 == seen1_q[lut_in])) // RQ2
    else $error("four-input table output wrong");
  a_five_input: assert property ((is_logic && five_q) |-> (out0 == (sel5 ? seen1_q[lut_in] : seen0_q[lut_in]) && !out1)) // RQ3
    else $error("five-input table output wrong");
  a_wide_chain: assert property ((is_logic && cat_sel) |-> wide_out == cat_in) // RQ4
    else $error("neighbour concatenation not passed");
  a_wide_own: assert property ((is_logic && !cat_sel) |-> wide_out == (sel5 ? seen1_q[lut_in] : seen0_q[lut_in])) // RQ3
    else $error("own five-input result not on the wide output");
  a_add_sub: assert property ((is_ripple && !is_count) |->
      {carry_out, sum_out} == ({1'b0, op_a} + {1'b0, (arith_q == CLS_ARITH_SUB) ? ~op_b : op_b} + {2'h0, carry_in})) // RQ5
    else $error("ripple add or subtract wrong");
  a_count_step: assert property ((is_ripple && cnt_en && !cfg_load && arith_q == CLS_ARITH_UP) ##1 (is_ripple && !cfg_load)
      |-> sum_out == $past(sum_out) + CLS_CNT_ONE) // RQ5
    else $error("up counter did not step");
  a_count_down: assert property ((is_ripple && cnt_en && !cfg_load && arith_q == CLS_ARITH_DOWN) |=>
      (sum_out == $past(sum_out) - CLS_CNT_ONE)) // RQ5
    else $error("down counter did not step");
  a_compare: assert property (is_ripple |-> cmp_out == ((cmp_q == CLS_CMP_GE) ? (op_a >= op_b) :
      (cmp_q == CLS_CMP_NE) ? (op_a != op_b) : (op_a <= op_b))) // RQ6
    else $error("comparator result wrong");
  a_fast_carry: assert property ((is_ripple && fast_q && !is_count) |-> carry_out == (cg_out | (cp_out & carry_in))) // RQ7
    else $error("fast carry terms disagree with carry");
  a_no_fast: assert property (!fast_q |-> (!cg_out && !cp_out)) // RQ7
    else $error("generate or propagate without fast carry");
  a_ram_readback: assert property ((is_ram && mem_we && !cfg_load && !ro_q) ##1 (!cfg_load && $stable(mem_addr))
      |-> mem_rdata == $past(mem_wdata)) // RQ12
    else $error("RAM word not read back after write");
  a_dual_port: assert property ((is_ram && ro_q && mem_we && !cfg_load) ##1 (!cfg_load && ro_addr == $past(mem_addr))
      |-> mem_rdata == $past(mem_wdata)) // RQ10
    else $error("read-only port missed the shared write");
  a_rom_hold: assert property ((mode_q == CLS_MODE_ROM && !cfg_load) ##1 (!cfg_load && $stable(tbl_raddr))
      |-> $stable(mem_rdata)) // RQ11
    else $error("ROM contents changed outside configuration");

  c_ram_write: cover property (is_ram && mem_we ##1 is_ram && !mem_we);
  c_count_wrap: cover property (is_ripple && is_count && carry_out);
  c_five_input: cover property (is_logic && five_q && sel5);
  c_fast_chain: cover property (is_ripple && fast_q && cp_out && carry_in);
  c_dual_write: cover property (is_ram && ro_q && mem_we && !cfg_load);

endmodule

// *** tb/cls_neighbour.sv ***
// Neighbouring slice of the same tile, feeding its table result to the concatenation input.
`timescale 1ns/1ns

module cls_neighbour #(
  parameter logic [31:0] IMAGE = 32'h0000_0000
) (
  input  wire logic [3:0] nb_in,
  input  wire logic       nb_sel,
  output logic            nb_out
);
  assign nb_out = IMAGE[{nb_sel, nb_in}];
endmodule

// *** tb/cls_slice_tb.sv ***
// Self-checking testbench for the configurable logic slice.
`timescale 1ns/1ns

module cls_slice_tb
  import cls_pkg::*;
;
  localparam logic [31:0] IMG = 32'h3C96_A5C3;
  localparam logic [31:0] NBI = 32'h6996_F00D;
  logic ref_clk, resetn, cfg_load, cfg_five_input, cfg_fast_carry, sel5, cat_in, cat_sel;
  logic carry_in, cnt_en, mem_we, out0, out1, wide_out, carry_out, cmp_out, cg_out, cp_out;
  cls_mode_type  cfg_mode;
  cls_mode_type  mode_out;
  cls_arith_type cfg_arith_op;
  cls_cmp_type   cfg_cmp_op;
  logic [15:0]   cfg_init0;
  logic [15:0]   cfg_init1;
  logic [3:0]    lut_in, mem_addr, ro_addr;
  logic [1:0]    op_a, op_b, mem_wdata, sum_out, mem_rdata, ro_rdata;
  int            n_mismatch;
  int            n_tests;

  cls_slice DUT (.ref_clk, .resetn, .cfg_load, .cfg_mode, .cfg_init0, .cfg_init1, .cfg_five_input,
    .cfg_arith_op, .cfg_cmp_op, .cfg_fast_carry, .cfg_read_only_port(1'b0), .lut_in, .sel5, .cat_in,
    .cat_sel, .op_a, .op_b, .carry_in, .cnt_en, .mem_addr, .mem_wdata, .mem_we, .ro_addr, .mode_out,
    .out0, .out1, .wide_out, .sum_out, .carry_out, .cmp_out, .cg_out, .cp_out, .mem_rdata);

  // The companion shares the write signals and reads through its own address.
  cls_slice DUT_RO (.ref_clk, .resetn, .cfg_load, .cfg_mode, .cfg_init0, .cfg_init1, .cfg_five_input,
    .cfg_arith_op, .cfg_cmp_op, .cfg_fast_carry, .cfg_read_only_port(1'b1), .lut_in, .sel5, .cat_in,
    .cat_sel, .op_a, .op_b, .carry_in, .cnt_en, .mem_addr, .mem_wdata, .mem_we, .ro_addr, .mode_out(),
    .out0(), .out1(), .wide_out(), .sum_out(), .carry_out(), .cmp_out(), .cg_out(), .cp_out(),
    .mem_rdata(ro_rdata));

  cls_neighbour #(.IMAGE(NBI)) NB (.nb_in(lut_in), .nb_sel(sel5), .nb_out(cat_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input cls_mode_type m, input logic five, input cls_arith_type op, input cls_cmp_type c);
    @(posedge ref_clk);
    cfg_mode <= m;
    cfg_five_input <= five;
    cfg_arith_op <= op;
    cfg_cmp_op <= c;
    cfg_load <= 1'b1;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    #2;
    chk(mode_out, m);
  endtask

  task automatic t_logic();
    load(CLS_MODE_LOGIC, 1'b0, CLS_ARITH_ADD, CLS_CMP_GE);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      lut_in <= i[3:0];
      #2;
      chk(out0, IMG[i[3:0]]);
      chk(out1, IMG[{1'b1, i[3:0]}]);
    end
    load(CLS_MODE_LOGIC, 1'b1, CLS_ARITH_ADD, CLS_CMP_GE);
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      lut_in <= i[3:0];
      sel5 <= i[4];
      cat_sel <= i[5];
      #2;
      chk(out0, IMG[i[4:0]]);
      chk(out1, 16'h0000);
      chk(wide_out, i[5] ? NBI[i[4:0]] : IMG[i[4:0]]);
    end
    $display("logic test done");
  endtask

  task automatic t_ripple();
    logic [1:0] y;
    logic [2:0] s;
    for (int k = 0; k < 3; k++) begin
      // The last pass runs without the fast carry variant, so generate and propagate must stay low.
      cfg_fast_carry <= (k != 2);
      load(CLS_MODE_RIPPLE, 1'b0, cls_arith_type'(k == 1 ? 1 : 0), cls_cmp_type'(k));
      for (int i = 0; i < 32; i++) begin
        @(posedge ref_clk);
        op_a <= i[1:0];
        op_b <= i[3:2];
        carry_in <= i[4];
        #2;
        y = (k == 1) ? ~i[3:2] : i[3:2];
        s = i[1:0] + y + i[4];
        chk(sum_out, s[1:0]);
        chk(carry_out, s[2]);
        chk(cmp_out, k == 0 ? i[1:0] >= i[3:2] : k == 1 ? i[1:0] != i[3:2] : i[1:0] <= i[3:2]);
        chk(cg_out, (k != 2) && (3'(i[1:0]) + 3'(y) > 3'h3));
        chk(cp_out, (k != 2) && ((i[1:0] ^ y) == 2'h3));
      end
    end
    $display("ripple test done");
  endtask

  task automatic t_count();
    logic [1:0] c;
    for (int k = 2; k < 4; k++) begin
      load(CLS_MODE_RIPPLE, 1'b0, cls_arith_type'(k), CLS_CMP_GE);
      cnt_en <= 1'b1;
      c = 2'h0;
      for (int i = 0; i < 6; i++) begin
        #1;
        chk(sum_out, c);
        chk(carry_out, (k == 2) ? c == 2'h3 : c == 2'h0);
        @(posedge ref_clk);
        #2;
        c = (k == 2) ? c + 2'h1 : c - 2'h1;
      end
      cnt_en <= 1'b0;
    end
    $display("count test done");
  endtask

  task automatic t_mem();
    load(CLS_MODE_RAM, 1'b0, CLS_ARITH_ADD, CLS_CMP_GE);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      mem_we <= 1'b1;
      mem_addr <= i[3:0];
      mem_wdata <= i[1:0] ^ 2'h2;
    end
    @(posedge ref_clk);
    mem_we <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      mem_addr <= i[3:0];
      ro_addr <= 4'hF - i[3:0];
      #2;
      chk(mem_rdata, i[1:0] ^ 2'h2);
      chk(ro_rdata, {~i[1], ~i[0]} ^ 2'h2);
    end
    load(CLS_MODE_ROM, 1'b0, CLS_ARITH_ADD, CLS_CMP_GE);
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      mem_we <= 1'b1;
      mem_addr <= i[4:1];
      mem_wdata <= ~{IMG[{1'b1, i[4:1]}], IMG[{1'b0, i[4:1]}]};
      #2;
      chk(mem_rdata, {IMG[{1'b1, i[4:1]}], IMG[{1'b0, i[4:1]}]});
    end
    mem_we <= 1'b0;
    $display("memory test done");
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole run is well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {resetn, cfg_load, cfg_five_input, sel5, cat_sel, carry_in, cnt_en, mem_we} = 8'h00;
    cfg_fast_carry = 1'b1;
    cfg_mode = CLS_MODE_LOGIC;
    cfg_arith_op = CLS_ARITH_ADD;
    cfg_cmp_op = CLS_CMP_GE;
    {cfg_init1, cfg_init0} = IMG;
    {lut_in, mem_addr, ro_addr, op_a, op_b, mem_wdata} = 18'h00000;
    n_mismatch = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    chk(mode_out, CLS_MODE_LOGIC);
    chk({sum_out, mem_rdata}, 16'h0000);
    t_logic();
    t_ripple();
    t_count();
    t_mem();
    end_of_test();
  end
endmodule
